/* File: hw/twb_pkg.sv */
// Purpose: Shared constants and types of the two-wire bus control block.
// Assumes: 8-bit special function register port, 40 MHz mclk.
// Notes:   Offsets are byte addresses on the register port.
package twb_pkg;

    // Register offsets
    localparam logic [7:0] OFS_PIN_FUNC   = 8'h9b;  // Pin function enable
    localparam logic [7:0] OFS_CTRL_PRI   = 8'hc2;  // Primary control
    localparam logic [7:0] OFS_CTRL_SEC   = 8'hc3;  // Secondary control
    localparam logic [7:0] OFS_OWN_ADDR   = 8'hc1;  // Own address
    localparam logic [7:0] OFS_STATUS     = 8'hc0;  // Status (fail, initiator)

    // Pin function enable fields
    localparam int BIT_SDA_TAKE    = 7;
    localparam int BIT_SCL_TAKE    = 6;
    localparam int BIT_PULSE_B     = 3;
    localparam int BIT_PULSE_A     = 2;
    // Primary control fields
    localparam int BIT_IF_ENABLE   = 7;
    localparam int BIT_BUSY        = 3;
    // Secondary control fields
    localparam int BIT_ADDR_HIT    = 7;
    localparam int BIT_RESP_DIR    = 6;
    localparam int BIT_REPEAT      = 3;
    localparam int BIT_INIT_DIR    = 0;
    // Own address fields
    localparam int BIT_NIBBLE_CMP  = 0;
    // Status fields
    localparam int BIT_XFER_FAIL   = 5;
    localparam int BIT_INIT_MODE   = 1;

    // Values after reset
    localparam logic [7:0] RST_PIN_FUNC  = 8'h00;
    localparam logic [2:0] RST_RATE      = 3'h1;  // Divide by 64
    localparam logic [7:0] RST_OWN_ADDR  = 8'h00;

    // Quarter-bit divider base: 8 mclk per quarter gives mclk/32 per bit
    localparam int          QTR_BASE     = 8;
    localparam int          DIV_W        = 10;    // Holds 8 << 7 = 1024 counts
    localparam int          BITS_ADDR    = 8;     // Address plus direction bit
    localparam logic [3:0]  ACK_INDEX    = 4'h8;  // Ninth clock is acknowledge

    // Initiator sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_BIT   = 3'b010,
        ST_HOLD  = 3'b011,
        ST_STOP  = 3'b100
    } twb_state_e;

endpackage : twb_pkg

/* File: hw/twb_rate_div.sv */
// Purpose: Quarter-bit tick generator for the initiator bit clock.
// Assumes: Selection code is stable while a transfer runs.
// Notes:   Four ticks make one bit, so the bit rate is mclk / (32 << sel).
`timescale 1ns/100ps
module twb_rate_div (
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     run,
    input  wire logic [2:0]               rate_sel,
    output logic                          qtr_tick
);
    logic [twb_pkg::DIV_W-1:0] cnt_q;  // Down counter
    logic [twb_pkg::DIV_W-1:0] reload; // Period minus one

    // Period doubles for every step of the code
    assign reload = (twb_pkg::DIV_W'(twb_pkg::QTR_BASE) << rate_sel) - 1'b1;

    // Counter restarts at zero while idle so the first tick comes one cycle after run rises
    always_ff @(posedge mclk) begin
        if (rst || !run) begin
            cnt_q    <= '0;
            qtr_tick <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q    <= reload;
            qtr_tick <= 1'b1;  // Fastest code gives 1.25 Mbit/s, over 400k
        end else begin
            cnt_q    <= cnt_q - 1'b1;
            qtr_tick <= 1'b0;
        end
    end
endmodule : twb_rate_div

/* File: hw/twb_bus_ctrl.sv */
// Purpose: Two-wire bus control: pin takeover, enable, busy, rate, address match.
// Assumes: Open-drain lines; an oe of 1 pulls the line low.
// Notes:   Data bytes after the address belong to the data path outside.
// Contract
// - Adjustable initiator rate reaching 400 kbit/s
// - Take bits hand lines to interface
// - Bit 3 enables second pulse output
// - Interface works only when enabled
// - Busy set on start, cleared on stop
// - Rate code divides by 32 up to 4096
// - Reset rate code divides by 64
// - Hit flag when address equals own
// - Nibble option compares upper four bits
// - Direction flag updated after a matching address is received
// - Direction flag zero after reset
// - Repeat bit issues start, resends address
// - Nack after repeat: fail, clear, release
// - Repeat bit self-clears after start, reset
// - Initiator direction bit sent as read/write
// - Initiator bit starts start plus address
// - Own address bits 7:1 send and compare
// - Fail flag stays until software clears
`timescale 1ns/100ps
module twb_bus_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  sfr_addr,      // Register address
    input  wire logic        sfr_wr,        // Write strobe, one cycle
    input  wire logic        sfr_rd,        // Read strobe, one cycle
    input  wire logic [7:0]  sfr_wdata,     // Write data
    output logic      [7:0]  sfr_rdata,     // Read data, valid cycle after strobe
    input  wire logic        scl_pin_in,    // Clock line level
    input  wire logic        sda_pin_in,    // Data line level
    input  wire logic        port_scl_out,  // Ordinary port output for clock pin
    input  wire logic        port_scl_oe,
    input  wire logic        port_sda_out,  // Ordinary port output for data pin
    input  wire logic        port_sda_oe,
    output logic             scl_out,
    output logic             scl_oe,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             pulse_a_en,    // Pulse output module enables
    output logic             pulse_b_en
);
    // Register state
    logic [7:0]  pin_func_q;         // Pin function enable
    logic        if_en_q;            // Interface enable
    logic        busy_q;             // Bus activity flag
    logic [2:0]  rate_q;             // Rate select
    logic        hit_q;              // Address hit flag
    logic        resp_dir_q;         // Responder direction flag
    logic        repeat_q;           // Repeat-start request
    logic        init_dir_q;         // Initiator direction bit
    logic [7:0]  own_addr_q;         // Own address and nibble option
    logic        fail_q;             // Transfer-fail flag
    logic        init_q;             // Initiator mode bit

    // Line synchronisers and edge history
    logic [1:0]  scl_sync_q;
    logic [1:0]  sda_sync_q;
    logic        scl_prev_q;
    logic        sda_prev_q;
    logic        scl_s;              // Synchronised clock line
    logic        sda_s;              // Synchronised data line
    logic        start_seen;         // Start condition on the bus
    logic        stop_seen;          // Stop condition on the bus
    logic        scl_rise;
    logic        scl_fall;

    // Initiator sequencer
    twb_pkg::twb_state_e state_q;
    logic [1:0]  qtr_q;              // Quarter within a bit
    logic [3:0]  bit_q;              // Bit index within the address frame
    logic [7:0]  shift_q;            // Address byte being sent
    logic        m_scl_low_q;        // Initiator pulls clock low
    logic        m_sda_low_q;        // Initiator pulls data low
    logic        was_repeat_q;       // Current address follows a repeated start
    logic        qtr_tick;
    logic        seq_run;

    // Responder receiver
    logic [3:0]  r_cnt_q;            // Bits taken since start
    logic [7:0]  r_shift_q;          // Received address byte
    logic        r_active_q;         // Address phase open
    logic        r_ack_q;            // Responder pulls data low for acknowledge

    // Write decode used by every register
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
        wr_hit = (a == ofs);
    endfunction : wr_hit

    // Address compare, full seven bits or upper nibble only
    function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own);
        if (own[twb_pkg::BIT_NIBBLE_CMP])
            addr_match = (rx[7:4] == own[7:4]);
        else
            addr_match = (rx[7:1] == own[7:1]);
    endfunction : addr_match

    assign scl_s      = scl_sync_q[1];
    assign sda_s      = sda_sync_q[1];
    assign start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
    assign stop_seen  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
    assign scl_rise   = scl_s && !scl_prev_q;
    assign scl_fall   = !scl_s && scl_prev_q;
    assign seq_run    = if_en_q && (state_q != twb_pkg::ST_IDLE);

    // Two-stage synchronisers; only the second stage feeds logic
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_pin_in};
            sda_sync_q <= {sda_sync_q[0], sda_pin_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // Bit clock divider
    twb_rate_div u_rate_div (
        .mclk     (mclk),
        .rst      (rst),
        .run      (seq_run),
        .rate_sel (rate_q),
        .qtr_tick (qtr_tick)
    );

    // Pin function enable register
    always_ff @(posedge mclk) begin
        if (rst)
            pin_func_q <= twb_pkg::RST_PIN_FUNC;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_PIN_FUNC))
            pin_func_q <= sfr_wdata & 8'hcc;  // Unused bits stay zero
    end

    // Primary control: enable and rate select
    always_ff @(posedge mclk) begin
        if (rst) begin
            if_en_q <= 1'b0;
            rate_q  <= twb_pkg::RST_RATE;
        end else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_CTRL_PRI)) begin
            if_en_q <= sfr_wdata[twb_pkg::BIT_IF_ENABLE];
            rate_q  <= sfr_wdata[2:0];
        end
    end

    // Bus activity: only watched while enabled, start sets, stop clears
    always_ff @(posedge mclk) begin
        if (rst || !if_en_q)
            busy_q <= 1'b0;
        else if (start_seen)
            busy_q <= 1'b1;
        else if (stop_seen)
            busy_q <= 1'b0;
    end

    // Own address register
    always_ff @(posedge mclk) begin
        if (rst)
            own_addr_q <= twb_pkg::RST_OWN_ADDR;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_OWN_ADDR))
            own_addr_q <= sfr_wdata;
    end

    // Initiator direction bit, plain software bit
    always_ff @(posedge mclk) begin
        if (rst)
            init_dir_q <= 1'b0;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_CTRL_SEC))
            init_dir_q <= sfr_wdata[twb_pkg::BIT_INIT_DIR];
    end

    // Repeat-start: software write wins over the hardware clear
    always_ff @(posedge mclk) begin
        if (rst)
            repeat_q <= 1'b0;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_CTRL_SEC))
            repeat_q <= sfr_wdata[twb_pkg::BIT_REPEAT] && init_q;
        // A repeated start or a nack consumes the request; one set during the first
        // start must survive it so the next acknowledge phase can act on it
        else if (state_q == twb_pkg::ST_START && qtr_tick && qtr_q == 2'h3
                 && was_repeat_q)
            repeat_q <= 1'b0;              // Repeated start generated
        else if (state_q == twb_pkg::ST_BIT && qtr_tick && qtr_q == 2'h3
                 && bit_q == twb_pkg::ACK_INDEX && sda_s)
            repeat_q <= 1'b0;
    end

    // Transfer-fail: nack sets it; only software clears, set wins
    always_ff @(posedge mclk) begin
        if (rst)
            fail_q <= 1'b0;
        else if (state_q == twb_pkg::ST_BIT && qtr_tick && qtr_q == 2'h3
                 && bit_q == twb_pkg::ACK_INDEX && sda_s)
            fail_q <= 1'b1;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_STATUS)
                 && !sfr_wdata[twb_pkg::BIT_XFER_FAIL])
            fail_q <= 1'b0;
    end

    // Initiator mode: software sets, sequencer clears after the stop
    always_ff @(posedge mclk) begin
        if (rst || !if_en_q)
            init_q <= 1'b0;
        else if (sfr_wr && wr_hit(sfr_addr, twb_pkg::OFS_STATUS))
            init_q <= sfr_wdata[twb_pkg::BIT_INIT_MODE];
        else if (state_q == twb_pkg::ST_STOP && qtr_tick && qtr_q == 2'h3)
            init_q <= 1'b0;
    end

    // Initiator sequencer; four quarters per bit, clock high in quarter 2 only.
    // Clock stretching and arbitration are left to the data path outside.
    always_ff @(posedge mclk) begin
        if (rst || !if_en_q) begin
            state_q      <= twb_pkg::ST_IDLE;
            qtr_q        <= 2'h0;
            bit_q        <= 4'h0;
            shift_q      <= 8'h00;
            m_scl_low_q  <= 1'b0;
            m_sda_low_q  <= 1'b0;
            was_repeat_q <= 1'b0;
        end else begin
            unique case (state_q)
                twb_pkg::ST_IDLE: begin
                    qtr_q <= 2'h0;
                    if (init_q && !busy_q) begin
                        state_q      <= twb_pkg::ST_START;
                        was_repeat_q <= 1'b0;
                    end
                end
                twb_pkg::ST_START: if (qtr_tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    unique case (qtr_q)
                        2'h0: m_sda_low_q <= 1'b0;          // Release data first
                        2'h1: m_scl_low_q <= 1'b0;          // Then clock high
                        2'h2: m_sda_low_q <= 1'b1;          // Data falls: start
                        2'h3: begin
                            m_scl_low_q <= 1'b1;
                            bit_q       <= 4'h0;
                            // Address bits 7:1 then direction
                            shift_q     <= {own_addr_q[7:1], init_dir_q};
                            state_q     <= twb_pkg::ST_BIT;
                        end
                    endcase
                end
                twb_pkg::ST_BIT: if (qtr_tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    unique case (qtr_q)
                        2'h0: begin
                            m_scl_low_q <= 1'b1;
                            // Acknowledge slot leaves data free for the responder
                            m_sda_low_q <= (bit_q != twb_pkg::ACK_INDEX) && !shift_q[7];
                        end
                        2'h1: ;                             // Data settles
                        2'h2: m_scl_low_q <= 1'b0;          // Clock high
                        2'h3: begin
                            m_scl_low_q <= 1'b1;
                            shift_q     <= {shift_q[6:0], 1'b0};
                            bit_q       <= bit_q + 4'h1;
                            if (bit_q == twb_pkg::ACK_INDEX) begin
                                // Nack releases the bus through a stop
                                state_q <= sda_s ? twb_pkg::ST_STOP : twb_pkg::ST_HOLD;
                            end
                        end
                    endcase
                end
                twb_pkg::ST_HOLD: begin
                    qtr_q       <= 2'h0;
                    m_scl_low_q <= 1'b1;           // Hold clock low between phases
                    if (repeat_q) begin
                        state_q      <= twb_pkg::ST_START;
                        was_repeat_q <= 1'b1;
                    end else if (!init_q) begin
                        state_q <= twb_pkg::ST_STOP;
                    end
                end
                twb_pkg::ST_STOP: if (qtr_tick) begin
                    qtr_q <= qtr_q + 2'h1;
                    unique case (qtr_q)
                        2'h0: begin
                            m_scl_low_q <= 1'b1;
                            m_sda_low_q <= 1'b1;
                        end
                        2'h1: ;
                        2'h2: m_scl_low_q <= 1'b0;          // Clock high
                        2'h3: begin
                            m_sda_low_q <= 1'b0;            // Data rises: stop
                            state_q     <= twb_pkg::ST_IDLE;
                        end
                    endcase
                end
                default: state_q <= twb_pkg::ST_IDLE;
            endcase
        end
    end

    // Responder address receiver; idle while disabled or in initiator mode
    always_ff @(posedge mclk) begin
        if (rst || !if_en_q) begin
            r_cnt_q    <= 4'h0;
            r_shift_q  <= 8'h00;
            r_active_q <= 1'b0;
            r_ack_q    <= 1'b0;
            hit_q      <= 1'b0;
            resp_dir_q <= 1'b0;
        end else if (start_seen && !init_q) begin
            r_cnt_q    <= 4'h0;
            r_active_q <= 1'b1;
            r_ack_q    <= 1'b0;
        end else if (stop_seen) begin
            r_active_q <= 1'b0;
            r_ack_q    <= 1'b0;
        end else if (r_active_q && scl_rise && r_cnt_q != twb_pkg::ACK_INDEX) begin
            r_shift_q <= {r_shift_q[6:0], sda_s};
            r_cnt_q   <= r_cnt_q + 4'h1;
        end else if (r_active_q && scl_fall && r_cnt_q == 4'(twb_pkg::BITS_ADDR)) begin
            if (!r_ack_q) begin
                hit_q   <= addr_match(r_shift_q, own_addr_q);
                r_ack_q <= addr_match(r_shift_q, own_addr_q);
                if (addr_match(r_shift_q, own_addr_q))
                    resp_dir_q <= r_shift_q[0];
            end else begin
                r_ack_q    <= 1'b0;        // Acknowledge clock done
                r_active_q <= 1'b0;
            end
        end
    end

    // Pin muxing; registered so every output comes from a flop
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_out <= 1'b1;
            scl_oe  <= 1'b0;
            sda_out <= 1'b1;
            sda_oe  <= 1'b0;
        end else begin
            if (pin_func_q[twb_pkg::BIT_SCL_TAKE]) begin
                scl_out <= 1'b0;
                scl_oe  <= if_en_q && m_scl_low_q;
            end else begin
                scl_out <= port_scl_out;
                scl_oe  <= port_scl_oe;
            end
            if (pin_func_q[twb_pkg::BIT_SDA_TAKE]) begin
                sda_out <= 1'b0;
                sda_oe  <= if_en_q && (m_sda_low_q || r_ack_q);
            end else begin
                sda_out <= port_sda_out;
                sda_oe  <= port_sda_oe;
            end
        end
    end

    // Pulse output enables
    always_ff @(posedge mclk) begin
        if (rst) begin
            pulse_a_en <= 1'b0;
            pulse_b_en <= 1'b0;
        end else begin
            pulse_a_en <= pin_func_q[twb_pkg::BIT_PULSE_A];
            pulse_b_en <= pin_func_q[twb_pkg::BIT_PULSE_B];
        end
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                twb_pkg::OFS_PIN_FUNC: sfr_rdata <= pin_func_q;
                twb_pkg::OFS_CTRL_PRI: sfr_rdata <= {if_en_q, 3'h0, busy_q, rate_q};
                twb_pkg::OFS_CTRL_SEC: sfr_rdata <= {hit_q, resp_dir_q, 2'h0,
                                                     repeat_q, 2'h0, init_dir_q};
                twb_pkg::OFS_OWN_ADDR: sfr_rdata <= own_addr_q;
                twb_pkg::OFS_STATUS:   sfr_rdata <= {2'h0, fail_q, 3'h0, init_q, 1'b0};
                default:               sfr_rdata <= 8'h00;
            endcase
        end
    end
endmodule : twb_bus_ctrl

/* File: test/twb_bus_ctrl_monitor.sv */
// Purpose: Port checker for twb_bus_ctrl.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound to the design at the foot.
`timescale 1ns/100ps
module twb_bus_ctrl_mon (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       pulse_a_en,
    input wire logic       pulse_b_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Lone pin function write, then a quiet cycle
    sequence pin_wr_s;
        sfr_wr && sfr_addr == 8'h9b ##1 !sfr_wr;
    endsequence
    // Read strobe at a given offset
    sequence rd_s(logic [7:0] a);
        sfr_rd && sfr_addr == a;
    endsequence
    pulse_b_a: assert property (pin_wr_s |=> pulse_b_en == $past(sfr_wdata[3], 2))
        else $error("pulse b enable wrong");
    pulse_a_a: assert property (pin_wr_s |=> pulse_a_en == $past(sfr_wdata[2], 2))
        else $error("pulse a enable wrong");
    // Reset itself is the cause here, so no disable
    rst_out_a: assert property (disable iff (1'b0) rst |=> !scl_oe && !sda_oe)
        else $error("lines driven in reset");
    unmapped_rd_a: assert property (rd_s(8'h55) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    pri_resv_a: assert property (rd_s(8'hc2) |=> sfr_rdata[6:4] == 3'h0)
        else $error("primary spare bits set");
    sec_resv_a: assert property (rd_s(8'hc3) |=> !sfr_rdata[5:4] && !sfr_rdata[2:1])
        else $error("secondary spare bits set");
    pin_resv_a: assert property (rd_s(8'h9b) |=> !sfr_rdata[5:4] && !sfr_rdata[1:0])
        else $error("pin spare bits set");
    // Write, idle, read back: enable and rate survive
    rate_back_a: assert property (sfr_wr && sfr_addr == 8'hc2 ##2 rd_s(8'hc2) |=>
        {sfr_rdata[7], sfr_rdata[2:0]} == $past({sfr_wdata[7], sfr_wdata[2:0]}, 3))
        else $error("rate readback wrong");
endmodule : twb_bus_ctrl_mon
bind twb_bus_ctrl twb_bus_ctrl_mon u_mon (.*);

/* File: test/twb_bus_peer.sv */
// Purpose: Far responder on the two-wire bus.
// Assumes: Lines resolved by the bench, pulled up.
// Notes:   Acks the address when ack_en is 1; logs address and starts.
`timescale 1ns/100ps
module twb_bus_peer (
    input wire logic  scl,
    input wire logic  sda,
    input wire logic  ack_en,
    output logic      sda_pull,
    output logic [7:0] addr_q,
    output int        starts
);
    int nfall = 99;  // Clock falls since start; 99 means no frame
    initial begin
        sda_pull = 0;
        addr_q = 0;
        starts = 0;
    end
    // Start and stop: data moves while clock is high
    always @(negedge sda) if (scl) begin
        nfall = 0;
        starts++;
    end
    always @(posedge sda) if (scl) nfall = 99;
    always @(posedge scl) if (nfall inside {[1:8]}) addr_q = {addr_q[6:0], sda};
    // Ack only for the ninth bit, so repeated start is never blocked
    always @(negedge scl) begin
        nfall++;
        sda_pull = ack_en && nfall == 9;
    end
endmodule : twb_bus_peer

/* File: test/twb_bus_ctrl_tb.sv */
// Purpose: Self-checking bench for twb_bus_ctrl.
// Assumes: 40 MHz mclk, inputs moved 2 ns after the edge.
// Notes:   Register table first, then bus transfers.
`timescale 1ns/100ps
module twb_bus_ctrl_tb;
    logic mclk = 0, rst = 1, wr = 0, rd = 0, ack_en = 0;
    logic [7:0] addr = 0, wd = 0, rdata, a_seen, v;
    logic pso = 1, pse = 0, pco = 1, pce = 0;
    logic so, se, co, ce, pa, pb, pull, scl_w, sda_w;
    logic ext_scl = 1, ext_sda = 1, ackd;  // Bench acting as far initiator
    int errors = 0, tests_run = 0, starts, cyc = 0, last = 0, per = 0, n;
    typedef struct { logic w; logic [7:0] a, d, x; } twb_row_s;
    twb_row_s rows [10] = '{'{0, 8'hc2, 8'h00, 8'h01}, '{0, 8'hc3, 8'h00, 8'h00},
        '{0, 8'h9b, 8'h00, 8'h00}, '{0, 8'hc0, 8'h00, 8'h00}, '{1, 8'h9b, 8'hff, 8'hcc},
        '{1, 8'hc2, 8'h7f, 8'h07}, '{1, 8'hc3, 8'hff, 8'h01}, '{1, 8'hc1, 8'h5b, 8'h5b},
        '{1, 8'h55, 8'hff, 8'h00}, '{1, 8'hc2, 8'h00, 8'h00}};
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) cyc++;
    // Bit period taken on the second address bit
    always @(posedge scl_w) begin
        if (u_peer.nfall == 2) per = cyc - last;
        last = cyc;
    end
    assign scl_w = !(ce && !co) && ext_scl;
    assign sda_w = !(se && !so) && !pull && ext_sda;
    twb_bus_ctrl u_dut (.mclk(mclk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_wdata(wd), .sfr_rdata(rdata), .scl_pin_in(scl_w), .sda_pin_in(sda_w),
        .port_scl_out(pco), .port_scl_oe(pce), .port_sda_out(pso), .port_sda_oe(pse),
        .scl_out(co), .scl_oe(ce), .sda_out(so), .sda_oe(se), .pulse_a_en(pa),
        .pulse_b_en(pb));
    twb_bus_peer u_peer (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .sda_pull(pull),
        .addr_q(a_seen), .starts(starts));
    // Idle cycle after each access keeps strobes from re-rising in one step
    task automatic wr_reg(input logic [7:0] a, d);
        addr = a;
        wd = d;
        wr = 1;
        @(posedge mclk) #2 wr = 0;
        @(posedge mclk) #2;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        addr = a;
        rd = 1;
        @(posedge mclk) #2 rd = 0;
        v = rdata;
        @(posedge mclk) #2;
    endtask : rd_reg
    task automatic cmp(input string nm, input logic [7:0] x, y);
        tests_run++;
        if (y !== x) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, x, y);
        end
    endtask : cmp
    task automatic tally_and_finish;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // Polls a bit; a bound that runs out ends the run
    task automatic wait_bit(input logic [7:0] a, input int b, input logic val);
        for (n = 0; n < 400; n++) begin
            rd_reg(a);
            if (v[b] === val) return;
        end
        errors++;
        $display("BAD wait %h exp %h got %h", a, val, v[b]);
        tally_and_finish();
    endtask : wait_bit
    // One line step every six cycles, well past the three-cycle input lag
    task automatic step(input logic c, d);
        repeat (6) @(posedge mclk);
        #2 ext_scl = c;
        ext_sda = d;
    endtask : step
    // Start, address byte, ack clock, stop; ackd holds the line during ack
    task automatic call(input logic [7:0] b);
        logic [9:0] s;
        s = {b, 2'b10};
        step(1, 0);
        for (int k = 9; k >= 0; k--) begin
            step(0, ext_sda);
            step(0, s[k]);
            step(1, s[k]);
            if (k == 1) ackd = sda_w;
        end
        step(1, 1);
    endtask : call
    initial begin
        repeat (2) @(posedge mclk);
        #2 rst = 0;
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            cmp("reg", rows[i].x, v);
        end
        cmp("idle oe", 8'h00, {ce, se});
        wr_reg(8'h9b, 8'h00);
        pse = 1;
        pso = 0;
        repeat (2) @(posedge mclk);
        #2 cmp("port", 8'h09, {se, so, ce, co});
        pse = 0;
        wr_reg(8'h9b, 8'hc0);
        wr_reg(8'hc1, 8'ha4);
        wr_reg(8'hc2, 8'h80);
        rd_reg(8'hc2);
        cmp("free", 8'h80, v);
        wr_reg(8'hc0, 8'h02);
        wait_bit(8'hc2, 3, 1);
        wait_bit(8'hc0, 1, 0);
        wait_bit(8'hc2, 3, 0);
        rd_reg(8'hc0);
        cmp("fail", 8'h20, v);
        cmp("addr", 8'ha5, a_seen);
        cmp("per", 8'd32, per[7:0]);
        wr_reg(8'hc0, 8'h20);
        rd_reg(8'hc0);
        cmp("fail kept", 8'h20, v);
        ack_en = 1;
        wr_reg(8'hc2, 8'h81);
        wr_reg(8'hc0, 8'h02);
        wait_bit(8'hc2, 3, 1);
        wr_reg(8'hc3, 8'h09);
        wait_bit(8'hc3, 3, 0);
        // The port drive test pulled data low once with clock high
        cmp("starts", 8'd4, starts[7:0]);
        wr_reg(8'hc0, 8'h00);
        wait_bit(8'hc2, 3, 0);
        rd_reg(8'hc0);
        cmp("acked", 8'h00, v);
        cmp("per 64", 8'd64, per[7:0]);
        cmp("addr 2", 8'ha5, a_seen);
        ack_en = 0;
        call(8'h30);
        cmp("miss ack", 8'h01, {7'h0, ackd});
        rd_reg(8'hc3);
        cmp("miss", 8'h01, v);
        call(8'ha5);
        cmp("hit ack", 8'h00, {7'h0, ackd});
        rd_reg(8'hc3);
        cmp("hit", 8'hc1, v);
        wr_reg(8'hc1, 8'ha5);
        call(8'ha1);
        rd_reg(8'hc3);
        cmp("nibble", 8'hc1, v);
        rst = 1;
        repeat (2) @(posedge mclk);
        #2 rst = 0;
        rd_reg(8'hc3);
        cmp("rst sec", 8'h00, v);
        rd_reg(8'hc2);
        cmp("rst pri", 8'h01, v);
        tally_and_finish();
    end
endmodule : twb_bus_ctrl_tb
